// ===== verilog/hdcr_pkg.sv
`default_nettype none
package hdcr_pkg;
   // ==========================================================
   // sizes
   localparam int HDCR_BITS = 6;
   // pin vector: data bits, then clock a, clock b, clear
   localparam int HDCR_PINS = HDCR_BITS + 3;
   localparam int HDCR_POS_CLK_A = HDCR_BITS;
   localparam int HDCR_POS_CLK_B = HDCR_BITS + 1;
   localparam int HDCR_POS_CLEAR = HDCR_BITS + 2;
   // ==========================================================
   // reset values
   localparam logic [HDCR_PINS-1:0] HDCR_PINS_RST = 9'h000;
   localparam logic [HDCR_BITS-1:0] HDCR_BITS_RST = 6'h00;
   localparam logic HDCR_CLK_RST = 1'b0;
   typedef logic [HDCR_BITS-1:0] hdcr_bits_t;
endpackage : hdcr_pkg
`default_nettype wire

// ===== verilog/hdcr_register.sv
`default_nettype none
// Notes on behaviour
// - six independent master/slave D flip-flops
// - effective clock is OR of both clocks
// - master follows data while clock low
// - clear high forces all true outputs low
// - clear acts without waiting for clock
// - complementary output is always inverted true
module hdcr_register (
   // system
   input wire logic clock,
   input wire logic rst_b,
   // pins from surrounding logic
   input wire hdcr_pkg::hdcr_bits_t bit_inputs,
   input wire logic clock_in_a,
   input wire logic clock_in_b,
   input wire logic master_clear,
   // output pairs
   output var hdcr_pkg::hdcr_bits_t true_outputs,
   output var hdcr_pkg::hdcr_bits_t comp_outputs
);
   import hdcr_pkg::*;

   // ==========================================================
   // pin synchroniser and agreement filter
   logic [HDCR_PINS-1:0] pins;
   logic [HDCR_PINS-1:0] pins_f;

   assign pins = {master_clear, clock_in_b, clock_in_a, bit_inputs};

   // clock or clear pulses shorter than two clock periods can be
   // lost in the filter; the surrounding logic must respect that
   for (genvar p = 0; p < HDCR_PINS; p++) begin : g_pin
      hdcr_pin_filter #(
         .RST_VALUE(HDCR_PINS_RST[p])
      ) i_hdcr_pin_filter (
         .clock(clock),
         .rst_b(rst_b),
         .pin(pins[p]),
         .level(pins_f[p])
      );
   end

   // ==========================================================
   // combined clock and its rising edge
   logic clk_comb;
   logic clk_prev_reg, clk_prev_next;
   logic clk_rise;
   logic clear_f;
   hdcr_bits_t data_f;

   always_comb begin
      data_f = pins_f[HDCR_BITS-1:0];
      clear_f = pins_f[HDCR_POS_CLEAR];
      clk_comb = pins_f[HDCR_POS_CLK_A] | pins_f[HDCR_POS_CLK_B];
      clk_prev_next = clk_comb;
      // one clock rising while the other is high gives no edge here
      clk_rise = clk_comb & ~clk_prev_reg;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         clk_prev_reg <= HDCR_CLK_RST;
      end else begin
         clk_prev_reg <= clk_prev_next;
      end
   end

   // ==========================================================
   // six master/slave cells
   hdcr_bits_t stored;

   for (genvar b = 0; b < HDCR_BITS; b++) begin : g_bit
      hdcr_bit_cell #(
         .RST_VALUE(HDCR_BITS_RST[b])
      ) i_hdcr_bit_cell (
         .clock(clock),
         .rst_b(rst_b),
         .data(data_f[b]),
         .clk_level(clk_comb),
         .clk_rise(clk_rise),
         .clear(clear_f),
         .stored(stored[b])
      );
   end

   // ==========================================================
   // outputs
   // the raw clear pin gates the outputs so the clear needs no clock
   // edge; the stored bits are cleared later through the synchroniser
   assign true_outputs = stored & ~{HDCR_BITS{master_clear}};
   assign comp_outputs = ~true_outputs;
endmodule : hdcr_register

// ==========================================================
// one pin: three stages and an agreement filter
module hdcr_pin_filter #(
   parameter logic RST_VALUE = 1'h0
) (
   // system
   input wire logic clock,
   input wire logic rst_b,
   // raw pin and its filtered level
   input wire logic pin,
   output var logic level
);
   import hdcr_pkg::*;

   // ==========================================================
   // synchroniser stages
   logic sync1_reg, sync1_next;
   logic sync2_reg, sync2_next;
   logic sync3_reg, sync3_next;

   always_comb begin
      sync1_next = pin;
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sync1_reg <= RST_VALUE;
         sync2_reg <= RST_VALUE;
         sync3_reg <= RST_VALUE;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sync3_reg <= sync3_next;
      end
   end

   // ==========================================================
   // agreement filter
   logic filt_reg, filt_next;
   logic agree;

   always_comb begin
      // a change only counts once the second and third stages agree
      agree = ~(sync2_reg ^ sync3_reg);
      filt_next = agree ? sync3_reg : filt_reg;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         filt_reg <= RST_VALUE;
      end else begin
         filt_reg <= filt_next;
      end
   end

   assign level = filt_reg;
endmodule : hdcr_pin_filter

// ==========================================================
// one bit: master stage and slave stage
module hdcr_bit_cell #(
   parameter logic RST_VALUE = 1'h0
) (
   // system
   input wire logic clock,
   input wire logic rst_b,
   // filtered controls
   input wire logic data,
   input wire logic clk_level,
   input wire logic clk_rise,
   input wire logic clear,
   // stored bit
   output var logic stored
);
   import hdcr_pkg::*;

   // ==========================================================
   // master stage
   logic master_reg, master_next;

   always_comb begin
      // transparent only while the combined clock is low
      master_next = clk_level ? master_reg : data;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         master_reg <= RST_VALUE;
      end else begin
         master_reg <= master_next;
      end
   end

   // ==========================================================
   // slave stage
   logic slave_reg, slave_next;

   always_comb begin
      slave_next = slave_reg;
      if (clear) begin
         // clear beats a clock edge seen in the same cycle
         slave_next = RST_VALUE;
      end else if (clk_rise) begin
         slave_next = master_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         slave_reg <= RST_VALUE;
      end else begin
         slave_reg <= slave_next;
      end
   end

   assign stored = slave_reg;
endmodule : hdcr_bit_cell
`default_nettype wire

// ===== verif/hdcr_monitor.sv
`default_nettype none
module hdcr_monitor (
   // system
   input wire logic clock,
   input wire logic rst_b,
   // pins
   input wire hdcr_pkg::hdcr_bits_t bit_inputs,
   input wire logic clock_in_a,
   input wire logic clock_in_b,
   input wire logic master_clear,
   // outputs
   input wire hdcr_pkg::hdcr_bits_t true_outputs,
   input wire hdcr_pkg::hdcr_bits_t comp_outputs
);
   timeunit 1ns;
   timeprecision 100ps;
   import hdcr_pkg::*;
   wire logic ck = clock_in_a | clock_in_b, clr = master_clear;
   wire hdcr_pkg::hdcr_bits_t q = true_outputs;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   inv_pair_a: assert property (comp_outputs == ~q) else $error("p");
   clear_low_a: assert property (clr |-> !q) else $error("c");
   load_data_a: assert property ($rose(ck) && !clr |-> ##5
      (clr || q == $past(bit_inputs, 5))) else $error("l");
   no_edge_a: assert property ($past(ck, 4) && $past(ck) &&
      $rose(clock_in_b) && !clr |-> ##5 $stable(q)) else $error("e");
   idle_hold_a: assert property ((!ck && !clr) [*4] |-> $stable(q))
      else $error("i");
   change_src_a: assert property ($changed(q) && !clr |->
      $past(ck, 2) || $past(clr)) else $error("s");
   clear_keep_a: assert property (clr [*5] ##1 1 |-> !q)
      else $error("k");
   cover property ($rose(ck) ##4 $changed(q));
   cover property ($rose(clr));
   cover property ($rose(clock_in_b) && clock_in_a);
endmodule : hdcr_monitor
`default_nettype wire

// ===== verif/hdcr_pins.sv
`default_nettype none
module hdcr_pins (
   // system
   input wire logic clock,
   // pins toward the register
   output var hdcr_pkg::hdcr_bits_t bit_inputs,
   output var logic clock_in_a,
   output var logic clock_in_b,
   output var logic master_clear
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      bit_inputs = 6'h00;
      clock_in_a = 1'h0;
      clock_in_b = 1'h0;
      master_clear = 1'h0;
   end
   task automatic set_clear(logic c);
      master_clear <= c;
   endtask : set_clear
   // data rests 4 edges before the clocks move, so set-up is met
   task automatic step(hdcr_pkg::hdcr_bits_t v, logic a, b);
      @(posedge clock) bit_inputs <= v;
      repeat (4) @(posedge clock);
      {clock_in_a, clock_in_b} <= {a, b};
      repeat (5) @(posedge clock);
   endtask : step
endmodule : hdcr_pins
`default_nettype wire

// ===== verif/hdcr_register_tb_top.sv
`default_nettype none
module hdcr_register_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, rst_b = 0, clock_in_a, clock_in_b, master_clear;
   hdcr_pkg::hdcr_bits_t bit_inputs, true_outputs, comp_outputs;
   int err_count = 0, tests_run = 0, n = 0;
   hdcr_register i_hdcr_register (.*);
   hdcr_pins i_hdcr_pins (.*);
   initial forever #12.5 clock = ~clock;
   always @(posedge clock) if (++n == 600) report_and_stop(1);
   task automatic check(string s, hdcr_pkg::hdcr_bits_t e, v = true_outputs);
      tests_run++;
      if (v !== e) err_count++;
      if (v !== e) $display("CHECK FAILED %s exp %h seen %h", s, e, v);
   endtask : check
   task automatic report_and_stop(int late = 0);
      err_count += late;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic t_load();
      hdcr_pkg::hdcr_bits_t v[4] = '{6'h15, 6'h2A, 6'h3F, 6'h01};
      for (int i = 0; i < 4; i++) begin
         i_hdcr_pins.step(v[i], i != 1, i > 0);
         #1 check("load", v[i]);
         check("pair", ~v[i], comp_outputs);
         i_hdcr_pins.step(~v[i], 1'b0, 1'b0);
         #1 check("idle", v[i]);
      end
      $display("load done");
   endtask : t_load
   task automatic t_cross_clear();
      i_hdcr_pins.step(6'h15, 1'b1, 1'b0);
      i_hdcr_pins.step(6'h2A, 1'b1, 1'b1);
      #1 check("cross", 6'h15);
      @(posedge clock) i_hdcr_pins.set_clear(1'b1);
      #1 check("clear", 6'h00);
      repeat (6) @(posedge clock);
      i_hdcr_pins.set_clear(1'b0);
      i_hdcr_pins.step(6'h3F, 1'b0, 1'b0);
      #1 check("kept", 6'h00);
      $display("cross and clear done");
   endtask : t_cross_clear
   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      t_load();
      t_cross_clear();
      report_and_stop();
   end
endmodule : hdcr_register_tb_top
bind hdcr_register hdcr_monitor i_hdcr_monitor (
   .clock(clock),
   .rst_b(rst_b),
   .bit_inputs(bit_inputs),
   .clock_in_a(clock_in_a),
   .clock_in_b(clock_in_b),
   .master_clear(master_clear),
   .true_outputs(true_outputs),
   .comp_outputs(comp_outputs)
);
`default_nettype wire
